/* logic/ebp_map.svh */
// Purpose: constants for the external bus pin controller
// Assumes: 50 MHz mclk
// Notes:   included by the package and the top module
`ifndef EBP_MAP_SVH
`define EBP_MAP_SVH
`define EBP_LANES        4
`define EBP_PAGE_BITS    8
`define EBP_PAGE_LSB     22
`define EBP_CRITICAL_IRQ_IN_N_LOW_NS  20
`define EBP_CRITICAL_IRQ_IN_N_HIGH_NS 20
`define EBP_CLK_NS       20
`define EBP_CRITICAL_IRQ_IN_N_LOW_CYC  ((`EBP_CRITICAL_IRQ_IN_N_LOW_NS + `EBP_CLK_NS - 1) / `EBP_CLK_NS)
`define EBP_CRITICAL_IRQ_IN_N_HIGH_CYC ((`EBP_CRITICAL_IRQ_IN_N_HIGH_NS + `EBP_CLK_NS - 1) / `EBP_CLK_NS)
`define EBP_WIDTH_8      2'h0
`define EBP_WIDTH_16     2'h1
`define EBP_WIDTH_32     2'h2
`endif

/* logic/ebp_pkg.sv */
// Purpose: types for the external bus pin controller
// Assumes: ebp_map.svh holds the numbers
// Notes:   none
`include "ebp_map.svh"
package ebp_pkg;
    // Boot ROM width codes
    typedef enum logic [1:0] {
        EBP_BOOT_8  = 2'h0,
        EBP_BOOT_16 = 2'h1,
        EBP_BOOT_32 = 2'h2
    } ebp_boot_t;
    // Memory access request from the internal controller
    typedef struct packed {
        logic       active;     // Access in progress
        logic       bank;       // Bank 0 or 1
        logic       is_dram;    // Target is DRAM
        logic       col_phase;  // Column address phase
        logic [3:0] lanes;      // Byte lanes enabled
        logic       xfer_cycle; // Data transfer cycle
        logic       last_wait;  // Final wait cycle
    } ebp_access_t;
    // DMA state from the internal controller
    typedef struct packed {
        logic       burst;      // One transfer per cycle
        logic       xfer_done;  // Transfer completes, next starts
        logic       active;     // Transfer running
        logic [3:0] ack;        // Channel acknowledges
    } ebp_dma_t;
    // Boot capture states
    typedef enum logic [1:0] {
        EBP_ST_RESET = 2'h0,
        EBP_ST_AFTER = 2'h1,
        EBP_ST_DONE  = 2'h2
    } ebp_boot_st_t;
endpackage

/* logic/ebp_pins.sv */
// Purpose: pin-level control of the external bus and memory strobes
// Assumes: single 50 MHz clock, synchronous active-low reset
// Notes:   pins from outside pass two flip-flops before use
//          outputs are registered; pin events show three edges later
//          the boot width decodes three edges after reset release
`timescale 1ns/100ps
`include "ebp_map.svh"
module ebp_pins #(
    parameter int LANES = `EBP_LANES,
    parameter int PBITS = `EBP_PAGE_BITS
) (
    // Clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // Internal controller side
    input  wire ebp_pkg::ebp_access_t acc,
    input  wire ebp_pkg::ebp_dma_t    dma,
    input  wire logic                 op_pending,
    input  wire logic [PBITS-1:0]     page_addr_out,
    output logic                      bus_fault,
    output logic                      critical_irq,
    output ebp_pkg::ebp_boot_t        boot_width,
    output logic                      boot_width_valid,
    output logic [PBITS-1:0]          page_addr_seen,
    output logic                      page_cross,
    // Pins: inputs
    input  wire logic                 boot_width_select,
    input  wire logic                 bus_fault_in,
    input  wire logic                 critical_irq_in_n,
    input  wire logic                 hold_grant,
    // Pins: outputs
    output logic                      addr_mux_column_select,
    output logic                      dma_transfer_strobe,
    output logic [3:0]                dma_ack_n,
    output logic [LANES-1:0]          column_strobe_n,
    output logic                      chip_select_bank0_n,
    output logic                      chip_select_bank1_n,
    // Pins: page address, two-way
    input  wire logic [PBITS-1:0]     page_addr_in,
    output logic [PBITS-1:0]          page_addr_o,
    output logic                      page_addr_oe
);
    import ebp_pkg::*;

    // Synchroniser stages for pins
    logic [4+PBITS-1:0] sync1;
    logic [4+PBITS-1:0] sync2;
    logic [4+PBITS-1:0] next_sync1;
    logic [4+PBITS-1:0] next_sync2;
    logic               boot_s;      // Synced boot width pin
    logic               fault_s;     // Synced fault pin
    logic               critical_irq_in_n_s;      // Synced irq pin
    logic               hold_s;      // Synced hold grant
    logic [PBITS-1:0]   page_s;      // Synced page address
    // Boot capture
    ebp_boot_st_t       boot_st;
    ebp_boot_st_t       next_boot_st;
    logic               boot_first;  // Sample during reset
    logic               next_boot_first;
    ebp_boot_t          next_boot_width;
    logic               next_boot_width_valid;
    logic               boot_wait;   // Second sample still in flight
    logic               next_boot_wait;
    // Critical irq tracking
    logic               critical_irq_in_n_low_seen;
    logic               next_critical_irq_in_n_low_seen;
    logic               next_critical_irq;
    // Fault, strobe and pin registers
    logic               next_bus_fault;
    logic               next_strobe;
    logic               next_mux;
    logic [3:0]         next_ack_n;
    logic [LANES-1:0]   next_cas_n;
    logic               next_cs0_n;
    logic               next_cs1_n;
    logic [PBITS-1:0]   next_page_o;
    logic               next_page_oe;
    logic [PBITS-1:0]   next_page_seen;
    logic               next_page_cross;

    // Synchroniser chain, second stage only read
    always_comb begin
        next_sync1 = {boot_width_select, bus_fault_in, critical_irq_in_n, hold_grant, page_addr_in};
        next_sync2 = sync1;
    end

    // Synchroniser flops run through reset: the boot strap is sampled
    // in reset, and pins idle at their true level so no false edge
    // or fault appears at release
    always_ff @(posedge mclk) begin
        sync1 <= next_sync1;
        sync2 <= next_sync2;
    end

    // Named views of the second stage
    assign boot_s  = sync2[PBITS+3];
    assign fault_s = sync2[PBITS+2];
    assign critical_irq_in_n_s  = sync2[PBITS+1];
    assign hold_s  = sync2[PBITS];
    assign page_s  = sync2[PBITS-1:0];

    // Boot width capture; the pin path keeps running in reset
    always_comb begin
        next_boot_st          = boot_st;
        next_boot_first       = boot_first;
        next_boot_width       = boot_width;
        next_boot_width_valid = boot_width_valid;
        next_boot_wait        = boot_wait;
        case (boot_st)
            EBP_ST_RESET: begin
                next_boot_first = boot_s;
                next_boot_st    = EBP_ST_AFTER;
            end
            EBP_ST_AFTER: begin
                if (!boot_wait) begin
                    // A strap tied to reset rises at release and needs
                    // two more edges to cross the synchroniser
                    next_boot_wait = 1'b1;
                end else begin
                    if (!boot_first && boot_s) begin
                        // Low in reset, high after: 16-bit
                        next_boot_width = EBP_BOOT_16;
                    end else if (boot_first && boot_s) begin
                        // High both times: 32-bit
                        next_boot_width = EBP_BOOT_32;
                    end else begin
                        // Low after release, either level in reset: 8-bit
                        next_boot_width = EBP_BOOT_8;
                    end
                    next_boot_width_valid = 1'b1;
                    next_boot_st          = EBP_ST_DONE;
                end
            end
            EBP_ST_DONE: begin
                next_boot_st = EBP_ST_DONE;
            end
            default: begin
                next_boot_st = EBP_ST_RESET;
            end
        endcase
    end

    // Boot registers; in reset the first sample is refreshed each edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            boot_st          <= EBP_ST_RESET;
            boot_width       <= EBP_BOOT_8;
            boot_width_valid <= 1'b0;
            boot_wait        <= 1'b0;
            boot_first       <= boot_s;
        end else begin
            boot_st          <= next_boot_st;
            boot_first       <= next_boot_first;
            boot_width       <= next_boot_width;
            boot_width_valid <= next_boot_width_valid;
            boot_wait        <= next_boot_wait;
        end
    end

    // Fault window: a pin fault only counts in the transfer or last wait
    always_comb begin
        next_bus_fault = acc.active && (acc.xfer_cycle || acc.last_wait) && !fault_s;
    end

    // Fault flag register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bus_fault <= 1'b0;
        end else begin
            bus_fault <= next_bus_fault;
        end
    end

    // Critical irq: remember a low, pulse on the following high
    always_comb begin
        next_critical_irq_in_n_low_seen = critical_irq_in_n_low_seen;
        next_critical_irq  = 1'b0;
        if (!critical_irq_in_n_s) begin
            // Low level seen, arm the detector
            next_critical_irq_in_n_low_seen = 1'b1;
        end else if (critical_irq_in_n_low_seen) begin
            // High after low: one pulse, then disarm
            next_critical_irq  = 1'b1;
            next_critical_irq_in_n_low_seen = 1'b0;
        end
    end

    // Critical irq registers; the synchroniser idles high, so no false edge
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            critical_irq_in_n_low_seen <= 1'b0;
            critical_irq  <= 1'b0;
        end else begin
            critical_irq_in_n_low_seen <= next_critical_irq_in_n_low_seen;
            critical_irq  <= next_critical_irq;
        end
    end

    // Memory strobes: mux select, column strobes, SRAM chip selects
    always_comb begin
        next_mux = acc.active && acc.is_dram && acc.col_phase;
        next_cas_n = '1;
        if (acc.active && acc.is_dram && acc.col_phase) begin
            // Only enabled lanes strobe in the column phase
            next_cas_n = ~acc.lanes[LANES-1:0];
        end
        next_cs0_n = !(acc.active && !acc.is_dram && !acc.bank);
        next_cs1_n = !(acc.active && !acc.is_dram && acc.bank);
    end

    // Memory strobe registers, all idle at reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            addr_mux_column_select <= 1'b0;
            column_strobe_n        <= '1;
            chip_select_bank0_n    <= 1'b1;
            chip_select_bank1_n    <= 1'b1;
        end else begin
            addr_mux_column_select <= next_mux;
            column_strobe_n        <= next_cas_n;
            chip_select_bank0_n    <= next_cs0_n;
            chip_select_bank1_n    <= next_cs1_n;
        end
    end

    // Shared strobe pin and DMA acknowledges
    always_comb begin
        // Acknowledges only while not held off
        next_ack_n = hold_s ? 4'hf : ~dma.ack;
        if (hold_s) begin
            next_strobe = op_pending;
        end else if (dma.burst) begin
            next_strobe = dma.active && (dma.ack != 4'h0);
        end else begin
            next_strobe = dma.xfer_done && (dma.ack != 4'h0);
        end
    end

    // Shared pin registers; acknowledge and strobe move together
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dma_ack_n           <= 4'hf;
            dma_transfer_strobe <= 1'b0;
        end else begin
            dma_ack_n           <= next_ack_n;
            dma_transfer_strobe <= next_strobe;
        end
    end

    // Page address: drive as master, watch while held off
    always_comb begin
        next_page_oe    = !hold_s;
        next_page_o     = page_addr_out;
        next_page_seen  = hold_s ? page_s : page_addr_seen;
        next_page_cross = hold_s && (page_s != page_addr_seen);
    end

    // Page address registers; lines released at reset
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            page_addr_oe   <= 1'b0;
            page_addr_o    <= '0;
            page_addr_seen <= '0;
            page_cross     <= 1'b0;
        end else begin
            page_addr_oe   <= next_page_oe;
            page_addr_o    <= next_page_o;
            page_addr_seen <= next_page_seen;
            page_cross     <= next_page_cross;
        end
    end
endmodule

/* sim/ebp_ext_model.sv */
// Purpose: board straps, fault source, irq source and alternate master
// Assumes: bench asks for events one cycle at a time
// Notes:   released page lines toggle so stale values never pass
`timescale 1ns/100ps
module ebp_ext_model (
    // Clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // Requests from the bench
    input  wire logic [1:0] strap,
    input  wire logic       fault_req,
    input  wire logic       irq_req,
    input  wire logic       master_drive,
    input  wire logic [7:0] master_addr,
    // Pins towards the device
    output logic            boot_width_select,
    output logic            bus_fault_in,
    output logic            critical_irq_in_n,
    output logic [7:0]      ext_addr
);
    logic [7:0] junk = 8'h55; // Pattern on released lines
    assign boot_width_select = (strap == 2'h2) ? rst_n : strap[0];
    assign bus_fault_in = !fault_req;
    assign critical_irq_in_n = !irq_req;
    assign ext_addr = master_drive ? master_addr : junk;
    // Changing pattern while released
    always_ff @(posedge mclk) begin
        junk <= ~junk;
    end
endmodule

/* sim/ebp_pins_properties.sv */
// Purpose: timing checks on the ebp_pins ports
// Assumes: outside pins pass two sync stages
// Notes:   bound into every ebp_pins
`timescale 1ns/100ps
module ebp_pins_chk #(
    parameter int LANES = 4,
    parameter int PBITS = 8
) (
    input wire logic                 mclk,
    input wire logic                 rst_n,
    input wire ebp_pkg::ebp_access_t acc,
    input wire ebp_pkg::ebp_dma_t    dma,
    input wire logic                 op_pending,
    input wire logic [PBITS-1:0]     page_addr_out,
    input wire logic                 bus_fault,
    input wire logic                 critical_irq,
    input wire ebp_pkg::ebp_boot_t   boot_width,
    input wire logic                 boot_width_valid,
    input wire logic                 bus_fault_in,
    input wire logic                 critical_irq_in_n,
    input wire logic                 hold_grant,
    input wire logic                 addr_mux_column_select,
    input wire logic                 dma_transfer_strobe,
    input wire logic [3:0]           dma_ack_n,
    input wire logic [LANES-1:0]     column_strobe_n,
    input wire logic                 chip_select_bank0_n,
    input wire logic                 chip_select_bank1_n,
    input wire logic [PBITS-1:0]     page_addr_o,
    input wire logic                 page_addr_oe
);
    import ebp_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_MUX: assert property (acc.active && acc.is_dram |=> addr_mux_column_select == $past(acc.col_phase))
        else $error("mux select wrong");
    AST_CAS: assert property (acc.active && acc.is_dram && acc.col_phase |=> column_strobe_n == ~$past(acc.lanes))
        else $error("column strobes wrong");
    AST_CAS_IDLE: assert property (!acc.active |=> &column_strobe_n)
        else $error("column strobe while idle");
    AST_CS: assert property (acc.active && !acc.is_dram |=>
        {chip_select_bank1_n, chip_select_bank0_n} == ($past(acc.bank) ? 2'h1 : 2'h2))
        else $error("chip select wrong");
    AST_FAULT_IGN: assert property (!(acc.active && (acc.xfer_cycle || acc.last_wait)) |=> !bus_fault)
        else $error("fault seen outside window");
    AST_FAULT: assert property (acc.active && (acc.xfer_cycle || acc.last_wait) && !$past(bus_fault_in, 2) |=> bus_fault)
        else $error("fault missed");
    AST_BURST: assert property (!$past(hold_grant, 2) && dma.burst && dma.active && (|dma.ack) |=> dma_transfer_strobe)
        else $error("burst strobe dropped");
    AST_SLOW: assert property (!$past(hold_grant, 2) && !dma.burst |=>
        dma_transfer_strobe == $past(dma.xfer_done && (|dma.ack)))
        else $error("slow strobe wrong");
    AST_REGAIN: assert property ($past(hold_grant, 2) |=> dma_transfer_strobe == $past(op_pending))
        else $error("regain request wrong");
    AST_ACK: assert property (1'b1 |=> dma_ack_n == ($past(hold_grant, 3) ? 4'hf : ~$past(dma.ack)))
        else $error("ack outputs wrong");
    AST_PAGE: assert property (!$past(hold_grant, 2) |=> page_addr_oe && page_addr_o == $past(page_addr_out))
        else $error("page bits not driven");
    AST_IRQ: assert property ($rose(critical_irq_in_n) |-> ##[1:4] critical_irq)
        else $error("critical irq missed");
    AST_IRQ_ONE: assert property (critical_irq |=> !critical_irq)
        else $error("critical irq too long");
    AST_BOOT: assert property (boot_width_valid |=> boot_width_valid && $stable(boot_width))
        else $error("boot width moved");
endmodule
bind ebp_pins ebp_pins_chk #(.LANES(LANES), .PBITS(PBITS)) u_chk (.*);

/* sim/ebp_pins_tb.sv */
// Purpose: scenarios for ebp_pins
// Assumes: inputs change on the falling edge
// Notes:   pin events reach outputs three edges later
`timescale 1ns/100ps
module ebp_pins_tb;
    import ebp_pkg::*;
    logic        mclk = 1'b0, rst_n = 1'b0, op_pending = 1'b0, hold_grant = 1'b0;
    logic        fault_req = 1'b0, irq_req = 1'b0, master_drive = 1'b0;
    logic [1:0]  strap = 2'h0;
    logic [7:0]  master_addr = 8'h00, page_addr_out = 8'h3c;
    ebp_access_t acc = '0;
    ebp_dma_t    dma = '0;
    ebp_boot_t   boot_width;
    logic        bus_fault, critical_irq, boot_width_valid, page_cross, addr_mux_column_select;
    logic        dma_transfer_strobe, chip_select_bank0_n, chip_select_bank1_n, page_addr_oe;
    logic        boot_width_select, bus_fault_in, critical_irq_in_n;
    logic [3:0]  dma_ack_n, column_strobe_n;
    logic [7:0]  page_addr_seen, page_addr_o, ext_addr;
    wire logic [7:0] page_addr_in = page_addr_oe ? page_addr_o : ext_addr; // Shared page lines
    int          err_total = 0, compares = 0, cyc = 0, n;
    ebp_pins dut (.*);
    ebp_ext_model u_ext (.*);
    always #10 mclk = ~mclk;
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic final_report();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic t_boot(input logic [1:0] mode, input logic [7:0] exp);
        strap = mode;
        rst_n = 1'b0;
        step(5);
        rst_n = 1'b1;
        step(4);
        chk({7'h0, boot_width_valid}, 8'h1);
        chk({6'h0, boot_width}, exp);
    endtask
    task automatic t_dram();
        logic [3:0] ln;
        for (int i = 0; i < 5; i++) begin
            ln = (i < 4) ? 4'h1 << i : 4'hf;
            acc = '{active: 1'b1, is_dram: 1'b1, lanes: ln, default: 1'b0};
            step(1);
            chk({7'h0, addr_mux_column_select}, 8'h0);
            chk({4'h0, column_strobe_n}, 8'h0f);
            acc.col_phase = 1'b1;
            step(1);
            chk({7'h0, addr_mux_column_select}, 8'h1);
            chk({4'h0, column_strobe_n}, {4'h0, ~ln});
        end
        for (int b = 0; b < 2; b++) begin
            acc = '{active: 1'b1, bank: b[0], lanes: 4'hf, default: 1'b0};
            step(1);
            chk({6'h0, chip_select_bank1_n, chip_select_bank0_n}, b[0] ? 8'h1 : 8'h2);
            chk({4'h0, column_strobe_n}, 8'h0f);
        end
        acc = '0;
    endtask
    task automatic t_fault();
        for (int c = 0; c < 3; c++) begin
            acc = '{active: 1'b1, xfer_cycle: c == 0, last_wait: c == 1, default: 1'b0};
            fault_req = 1'b1;
            step(1);
            fault_req = 1'b0;
            n = 0;
            repeat (5) begin
                step(1);
                n += bus_fault;
            end
            chk(n[7:0], (c < 2) ? 8'h1 : 8'h0);
        end
        acc = '0;
    endtask
    task automatic t_dma();
        dma = '{active: 1'b1, ack: 4'h2, default: 1'b0};
        step(1);
        chk({4'h0, dma_ack_n}, 8'h0d);
        dma.xfer_done = 1'b1;
        step(1);
        dma.xfer_done = 1'b0;
        chk({7'h0, dma_transfer_strobe}, 8'h1);
        step(1);
        chk({7'h0, dma_transfer_strobe}, 8'h0);
        dma.burst = 1'b1;
        n = 0;
        repeat (6) begin
            step(1);
            n += dma_transfer_strobe;
        end
        chk(n[7:0], 8'h6);
        dma.ack = 4'h0;
        step(1);
        chk({7'h0, dma_transfer_strobe}, 8'h0);
        dma = '0;
    endtask
    task automatic t_hold();
        hold_grant = 1'b1;
        master_drive = 1'b1;
        master_addr = 8'h5a;
        op_pending = 1'b1;
        step(7);
        chk({7'h0, dma_transfer_strobe}, 8'h1);
        chk({3'h0, page_addr_oe, dma_ack_n}, 8'h0f);
        chk(page_addr_seen, 8'h5a);
        op_pending = 1'b0;
        master_addr = 8'ha5;
        n = 0;
        repeat (5) begin
            step(1);
            n += page_cross;
        end
        chk(n[7:0], 8'h1);
        chk({7'h0, dma_transfer_strobe}, 8'h0);
        hold_grant = 1'b0;
        master_drive = 1'b0;
        step(5);
        chk({7'h0, page_addr_oe}, 8'h1);
        chk(page_addr_o, 8'h3c);
    endtask
    task automatic t_irq();
        irq_req = 1'b1;
        step(1);
        irq_req = 1'b0;
        n = 0;
        repeat (6) begin
            step(1);
            n += critical_irq;
        end
        chk(n[7:0], 8'h1);
    endtask
    // Main sequence
    initial begin
        t_boot(2'h0, 8'h0);
        t_boot(2'h1, 8'h2);
        t_boot(2'h2, 8'h1);
        t_dram();
        t_fault();
        t_dma();
        t_hold();
        t_irq();
        final_report();
    end
endmodule
